/* File: vip_pkg.sv */
// vip_pkg: constants for the vectored interrupt priority unit.
// assumes one 125 MHz clock, apb register access, 11 maskable sources.
package vip_pkg;

    // ==========================================================
    // sizes
    localparam int unsigned NUM_SRC = 11;
    localparam int unsigned IDX_W   = 4;
    localparam int unsigned KEY_W   = 8;

    // ==========================================================
    // source indices, equal to their priority level
    localparam logic [IDX_W-1:0] SRC_WDT      = 4'h0;
    localparam logic [IDX_W-1:0] SRC_USB_TMR  = 4'h1;
    localparam logic [IDX_W-1:0] SRC_USB_TOK  = 4'h2;
    localparam logic [IDX_W-1:0] SRC_USB_RXD  = 4'h3;
    localparam logic [IDX_W-1:0] SRC_USB_TXD  = 4'h4;
    localparam logic [IDX_W-1:0] SRC_USB_RES  = 4'h5;
    localparam logic [IDX_W-1:0] SRC_EXT_PIN  = 4'h6;
    localparam logic [IDX_W-1:0] SRC_SERIAL   = 4'h7;
    localparam logic [IDX_W-1:0] SRC_TMR_A    = 4'h8;
    localparam logic [IDX_W-1:0] SRC_TMR_B    = 4'h9;
    localparam logic [IDX_W-1:0] SRC_KEY      = 4'ha;

    // ==========================================================
    // vector table
    localparam logic [15:0] NMI_VECTOR   = 16'h0004;
    localparam logic [15:0] MASK_VEC_LO  = 16'h0004;
    localparam logic [15:0] VEC_STEP     = 16'h0002;

    // ==========================================================
    // register byte offsets
    localparam logic [7:0] OFS_REQ_FLAG  = 8'h00;
    localparam logic [7:0] OFS_MASK_FLAG = 8'h04;
    localparam logic [7:0] OFS_EXT_EDGE  = 8'h08;
    localparam logic [7:0] OFS_KEY_SEL   = 8'h0c;
    localparam logic [7:0] OFS_CTRL      = 8'h10;
    localparam logic [7:0] OFS_STATUS    = 8'h14;

    // ==========================================================
    // fields and reset values
    localparam int unsigned CTRL_GE_BIT   = 0;
    localparam int unsigned CTRL_WDTI_BIT = 1;
    localparam int unsigned STAT_NMI_BIT  = 0;
    localparam int unsigned STAT_REQ_BIT  = 1;
    localparam int unsigned STAT_IDX_LSB  = 4;
    localparam logic [10:0] RST_REQ_FLAG  = 11'h000;
    localparam logic [10:0] RST_MASK_FLAG = 11'h7ff;
    localparam logic [1:0]  RST_EXT_EDGE  = 2'h0;
    localparam logic [7:0]  RST_KEY_SEL   = 8'h00;
    localparam logic [7:0]  KEY_SEL_WMASK = 8'hf1;

    // ext_edge_select encodings
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;
    localparam logic [1:0] EDGE_NONE = 2'h3;

    // maskable vector from priority index
    function automatic logic [15:0] vip_vector(input logic [IDX_W-1:0] idx);
        vip_vector = (idx == SRC_WDT) ? MASK_VEC_LO
                   : 16'(MASK_VEC_LO + VEC_STEP * {12'h000, idx});
    endfunction : vip_vector

endpackage : vip_pkg

/* File: vip_edge_det.sv */
// vip_edge_det: per-bit edge detector with separate rise/fall enables.
// assumes inputs synchronous to ref_clk.
`timescale 1ns/10ps
module vip_edge_det #(
    parameter int unsigned W = 1
) (
    input  wire logic         ref_clk,
    input  wire logic         srst,
    input  wire logic [W-1:0] sig,
    input  wire logic [W-1:0] rise_en,
    input  wire logic [W-1:0] fall_en,
    output logic              edge_hit
);
    logic [W-1:0] prev_ff;

    // previous sample tracks the pin in reset, so either idle level gives no edge at release
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            prev_ff <= sig;
        end else begin
            prev_ff <= sig;
        end
    end

    assign edge_hit = |(((sig & ~prev_ff) & rise_en) | ((~sig & prev_ff) & fall_en));

endmodule : vip_edge_det

/* File: vip_prio_enc.sv */
// vip_prio_enc: fixed priority pick, lowest index wins.
// assumes the pending vector is already masked; global enable is applied after the pick.
`timescale 1ns/10ps
module vip_prio_enc
    import vip_pkg::*;
(
    input  wire logic [NUM_SRC-1:0] pending,
    output logic                    any,
    output logic [IDX_W-1:0]        idx
);
    always_comb begin
        any = 1'b0;
        idx = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (pending[i]) begin
                any = 1'b1;
                idx = IDX_W'(i);
            end
        end
    end

endmodule : vip_prio_enc

/* File: vip_intc.sv */
// vip_intc: vectored interrupt unit, one nmi and eleven maskable sources.
// assumes apb master, single-cycle source pulses, a core that acks requests.
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/10ps
module vip_intc
    import vip_pkg::*;
(
    input  wire logic               ref_clk,
    input  wire logic               srst,
    // apb slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    // source events
    input  wire logic               wdt_overflow,
    input  wire logic               usb_timer_overflow_req,
    input  wire logic               usb_token_rx_eop_req,
    input  wire logic               usb_data_rx_eop_req,
    input  wire logic               usb_data_tx_eop_req,
    input  wire logic               usb_bus_resume_req,
    input  wire logic               ext_pin,
    input  wire logic               serial3w_done_req,
    input  wire logic               timer_a_match_req,
    input  wire logic               timer_b_match_req,
    input  wire logic [KEY_W-1:0]   key_pin_n,
    // core side
    output logic                    int_req,
    output logic                    int_nmi,
    output logic [15:0]             int_vector,
    input  wire logic               int_ack,
    input  wire logic               nmi_return,
    output logic                    global_enable_flag
);

    // ==========================================================
    // state
    logic [NUM_SRC-1:0] req_flag_ff;
    logic [NUM_SRC-1:0] mask_flag_ff;
    logic [1:0]         ext_edge_select_ff;
    logic [KEY_W-1:0]   key_pin_select_ff;
    logic               ge_ff;
    logic               wdt_interval_ff;
    logic               nmi_pend_ff;
    logic               nmi_busy_ff;
    logic               req_ff;
    logic               req_nmi_ff;
    logic [IDX_W-1:0]   req_idx_ff;
    logic [15:0]        vec_ff;

    logic [NUM_SRC-1:0] nxt_req_flag;
    logic [NUM_SRC-1:0] src_set;
    logic [NUM_SRC-1:0] fwd;
    logic               ext_pin_edge_req;
    logic               key_return_req;
    logic               pick_any;
    logic [IDX_W-1:0]   pick_idx;
    logic               nmi_cand;
    logic               accept;
    logic               wr_en;
    logic               addr_hit;
    logic [KEY_W-1:0]   key_fall_en;
    logic               edge_rise_en;
    logic               edge_fall_en;

    // ==========================================================
    // apb decode: zero wait states
    assign pready   = 1'b1;
    assign addr_hit = (paddr == OFS_REQ_FLAG) || (paddr == OFS_MASK_FLAG)
                   || (paddr == OFS_EXT_EDGE) || (paddr == OFS_KEY_SEL)
                   || (paddr == OFS_CTRL)     || (paddr == OFS_STATUS);
    assign wr_en    = psel && penable && pwrite && addr_hit;
    assign pslverr  = psel && penable && !addr_hit;

    always_comb begin
        prdata = 32'h0000_0000;
        unique case (paddr)
            OFS_REQ_FLAG:  prdata[NUM_SRC-1:0] = req_flag_ff;
            OFS_MASK_FLAG: prdata[NUM_SRC-1:0] = mask_flag_ff;
            OFS_EXT_EDGE:  prdata[1:0] = ext_edge_select_ff;
            OFS_KEY_SEL:   prdata[KEY_W-1:0] = key_pin_select_ff;
            OFS_CTRL: begin
                prdata[CTRL_GE_BIT]   = ge_ff;
                prdata[CTRL_WDTI_BIT] = wdt_interval_ff;
            end
            OFS_STATUS: begin
                prdata[STAT_NMI_BIT] = nmi_busy_ff;
                prdata[STAT_REQ_BIT] = req_ff;
                prdata[STAT_IDX_LSB +: IDX_W] = req_idx_ff;
            end
            default: prdata = 32'h0000_0000;
        endcase
    end

    // ==========================================================
    // pin edge detection
    // key inputs 0..3 share one select bit, 4..7 have their own
    assign key_fall_en = {key_pin_select_ff[7:4], {4{key_pin_select_ff[0]}}};

    assign edge_rise_en = (ext_edge_select_ff == EDGE_RISE) || (ext_edge_select_ff == EDGE_BOTH);
    assign edge_fall_en = (ext_edge_select_ff == EDGE_FALL) || (ext_edge_select_ff == EDGE_BOTH);

    vip_edge_det #(.W(1)) u_ext_edge (
        .ref_clk  (ref_clk),
        .srst     (srst),
        .sig      (ext_pin),
        .rise_en  (edge_rise_en),
        .fall_en  (edge_fall_en),
        .edge_hit (ext_pin_edge_req)
    );

    vip_edge_det #(.W(KEY_W)) u_key_edge (
        .ref_clk  (ref_clk),
        .srst     (srst),
        .sig      (key_pin_n),
        .rise_en  ({KEY_W{1'b0}}),
        .fall_en  (key_fall_en),
        .edge_hit (key_return_req)
    );

    // ==========================================================
    // source collection, bit index is the priority level
    assign src_set[SRC_WDT]     = wdt_overflow && wdt_interval_ff;
    assign src_set[SRC_USB_TMR] = usb_timer_overflow_req;
    assign src_set[SRC_USB_TOK] = usb_token_rx_eop_req;
    assign src_set[SRC_USB_RXD] = usb_data_rx_eop_req;
    assign src_set[SRC_USB_TXD] = usb_data_tx_eop_req;
    assign src_set[SRC_USB_RES] = usb_bus_resume_req;
    assign src_set[SRC_EXT_PIN] = ext_pin_edge_req;
    assign src_set[SRC_SERIAL]  = serial3w_done_req;
    assign src_set[SRC_TMR_A]   = timer_a_match_req;
    assign src_set[SRC_TMR_B]   = timer_b_match_req;
    assign src_set[SRC_KEY]     = key_return_req;

    // ==========================================================
    // request flags: a new event wins over any clear in the same cycle
    always_comb begin
        nxt_req_flag = req_flag_ff;
        if (wr_en && paddr == OFS_REQ_FLAG) begin
            nxt_req_flag = pwdata[NUM_SRC-1:0];
        end
        if (accept && !req_nmi_ff) begin
            nxt_req_flag[req_idx_ff] = 1'b0;
        end
        nxt_req_flag = nxt_req_flag | src_set;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            req_flag_ff <= RST_REQ_FLAG;
        end else begin
            req_flag_ff <= nxt_req_flag;
        end
    end

    // ==========================================================
    // software configuration
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            mask_flag_ff       <= RST_MASK_FLAG;
            ext_edge_select_ff <= RST_EXT_EDGE;
            key_pin_select_ff  <= RST_KEY_SEL;
            wdt_interval_ff    <= 1'b0;
        end else if (wr_en) begin
            if (paddr == OFS_MASK_FLAG) begin
                mask_flag_ff <= pwdata[NUM_SRC-1:0];
            end
            if (paddr == OFS_EXT_EDGE) begin
                ext_edge_select_ff <= pwdata[1:0];
            end
            // bits 1..3 are fixed at zero
            if (paddr == OFS_KEY_SEL) begin
                key_pin_select_ff <= pwdata[KEY_W-1:0] & KEY_SEL_WMASK;
            end
            if (paddr == OFS_CTRL) begin
                wdt_interval_ff <= pwdata[CTRL_WDTI_BIT];
            end
        end
    end

    // global enable: set by software, dropped on any acceptance
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ge_ff <= 1'b0;
        end else if (accept) begin
            ge_ff <= 1'b0;
        end else if (wr_en && paddr == OFS_CTRL) begin
            ge_ff <= pwdata[CTRL_GE_BIT];
        end
    end
    assign global_enable_flag = ge_ff;

    // ==========================================================
    // nonmaskable path
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            nmi_pend_ff <= 1'b0;
        end else if (wdt_overflow && !wdt_interval_ff) begin
            nmi_pend_ff <= 1'b1;
        end else if (accept && req_nmi_ff) begin
            nmi_pend_ff <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            nmi_busy_ff <= 1'b0;
        end else if (accept && req_nmi_ff) begin
            nmi_busy_ff <= 1'b1;
        end else if (nmi_return) begin
            nmi_busy_ff <= 1'b0;
        end
    end

    // ==========================================================
    // arbitration; nmi ignores mask and global enable
    assign fwd = req_flag_ff & ~mask_flag_ff;

    vip_prio_enc u_prio (
        .pending (fwd),
        .any     (pick_any),
        .idx     (pick_idx)
    );

    // a second nmi waits until the running one returns
    assign nmi_cand = nmi_pend_ff && !nmi_busy_ff;
    assign accept   = int_ack && req_ff;

    // request is re-evaluated each cycle; the cycle after accept is dead
    // so the cleared flag cannot be offered twice
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            req_ff     <= 1'b0;
            req_nmi_ff <= 1'b0;
            req_idx_ff <= '0;
            vec_ff     <= 16'h0000;
        end else if (accept) begin
            req_ff     <= 1'b0;
            req_nmi_ff <= 1'b0;
        end else if (nmi_cand) begin
            req_ff     <= 1'b1;
            req_nmi_ff <= 1'b1;
            vec_ff     <= NMI_VECTOR;
        end else begin
            req_ff     <= pick_any && ge_ff;
            req_nmi_ff <= 1'b0;
            req_idx_ff <= pick_idx;
            vec_ff     <= vip_vector(pick_idx);
        end
    end

    assign int_req    = req_ff;
    assign int_nmi    = req_nmi_ff;
    assign int_vector = vec_ff;

    // ==========================================================
    // checks
    sequence s_nmi_accept;
        accept && req_nmi_ff;
    endsequence

    property p_nmi_vector;
        @(posedge ref_clk) disable iff (srst)
        int_nmi |-> int_req && int_vector == 16'h0004;
    endproperty
    a_nmi_vector: assert property (p_nmi_vector) else $error("nmi vector wrong");

    property p_wdt_form;
        @(posedge ref_clk) disable iff (srst)
        wdt_overflow && !wdt_interval_ff |=> nmi_pend_ff && !req_flag_ff[0];
    endproperty
    a_wdt_form: assert property (p_wdt_form) else $error("watchdog form wrong");

    property p_wdt_mask;
        @(posedge ref_clk) disable iff (srst)
        wdt_overflow && wdt_interval_ff |=> req_flag_ff[0];
    endproperty
    a_wdt_mask: assert property (p_wdt_mask) else $error("watchdog flag not set");

    property p_ge_gate;
        @(posedge ref_clk) disable iff (srst)
        int_req && !int_nmi |-> $past(ge_ff);
    endproperty
    a_ge_gate: assert property (p_ge_gate) else $error("request without enable");

    property p_masked;
        @(posedge ref_clk) disable iff (srst)
        int_req && !int_nmi |-> ($past(mask_flag_ff) & (11'h001 << req_idx_ff)) == 11'h000;
    endproperty
    a_masked: assert property (p_masked) else $error("masked source forwarded");

    property p_vec_map;
        @(posedge ref_clk) disable iff (srst)
        int_req && !int_nmi && req_idx_ff != 4'h0 |->
            int_vector == 16'h0004 + {11'h000, req_idx_ff, 1'b0};
    endproperty
    a_vec_map: assert property (p_vec_map) else $error("vector map wrong");

    property p_prio;
        @(posedge ref_clk) disable iff (srst)
        ##1 int_req && !int_nmi && req_idx_ff != 4'h0 |->
            ($past(fwd) & ((11'h001 << req_idx_ff) - 11'h001)) == 11'h000;
    endproperty
    a_prio: assert property (p_prio) else $error("priority order wrong");

    property p_accept;
        @(posedge ref_clk) disable iff (srst)
        accept |=> !ge_ff && !int_req;
    endproperty
    a_accept: assert property (p_accept) else $error("accept side effects");

    property p_nmi_busy;
        @(posedge ref_clk) disable iff (srst)
        s_nmi_accept |=> nmi_busy_ff ##1 (nmi_busy_ff || $past(nmi_return));
    endproperty
    a_nmi_busy: assert property (p_nmi_busy) else $error("nmi busy flag lost");

    property p_key_off;
        @(posedge ref_clk) disable iff (srst)
        key_pin_select_ff == 8'h00 |-> !key_return_req;
    endproperty
    a_key_off: assert property (p_key_off) else $error("disabled key fired");

endmodule : vip_intc

/* File: vip_core_model.sv */
// vip_core_model: behavioural processor core facing the interrupt unit.
// assumes int_req/int_nmi come from registers, single clock ref_clk.
`timescale 1ns/10ps
module vip_core_model (
    input  wire logic       ref_clk,
    input  wire logic       srst,
    input  wire logic       int_req,
    input  wire logic       int_nmi,
    input  wire logic [3:0] ack_dly,
    input  wire logic [7:0] ret_dly,
    output logic            int_ack,
    output logic            nmi_return
);
    // ==========================================================
    // acceptance
    logic [3:0] wait_ff;
    logic [7:0] ret_ff;

    // ack stands one cycle; the unit holds int_req steady until then
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            int_ack <= 1'b0;
            wait_ff <= 4'h0;
        end else begin
            int_ack <= 1'b0;
            if (int_ack || !int_req) begin
                wait_ff <= 4'h0;
            end else if (wait_ff >= ack_dly) begin
                int_ack <= 1'b1;
            end else begin
                wait_ff <= wait_ff + 4'h1;
            end
        end
    end

    // ==========================================================
    // return from the nmi handler after ret_dly cycles
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ret_ff     <= 8'h00;
            nmi_return <= 1'b0;
        end else begin
            nmi_return <= 1'b0;
            if (int_ack && int_req && int_nmi) begin
                ret_ff <= ret_dly;
            end else if (ret_ff == 8'h01) begin
                nmi_return <= 1'b1;
                ret_ff     <= 8'h00;
            end else if (ret_ff != 8'h00) begin
                ret_ff <= ret_ff - 8'h01;
            end
        end
    end
endmodule : vip_core_model

/* File: tb.sv */
// tb: self-checking bench for vip_intc with a behavioural core.
// assumes zero-wait apb slave and registered request outputs.
`timescale 1ns/10ps
module tb
    import vip_pkg::*;
;
    typedef struct packed {logic [31:0] m; logic [31:0] e; logic err;} vip_rd_s;
    logic        ref_clk = 1'b0;
    logic        srst;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, v;
    logic [10:0] src_pulse, pend;
    logic        ext_pin, int_req, int_nmi, int_ack, nmi_return, global_enable_flag;
    logic [7:0]  key_pin_n, ret_dly;
    logic [15:0] int_vector;
    logic [3:0]  ack_dly;
    vip_rd_s     rd_q[$];
    vip_rd_s     r_now;
    logic [16:0] acc_q[$];
    int          err_count = 0;
    int          compares  = 0;
    int          acc_cnt   = 0;
    int          k;
    integer      seed      = 32'h5e21;

    always #4 ref_clk = ~ref_clk;

    vip_intc dut (
        .ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .wdt_overflow(src_pulse[0]), .usb_timer_overflow_req(src_pulse[1]),
        .usb_token_rx_eop_req(src_pulse[2]), .usb_data_rx_eop_req(src_pulse[3]),
        .usb_data_tx_eop_req(src_pulse[4]), .usb_bus_resume_req(src_pulse[5]),
        .ext_pin(ext_pin), .serial3w_done_req(src_pulse[7]),
        .timer_a_match_req(src_pulse[8]), .timer_b_match_req(src_pulse[9]),
        .key_pin_n(key_pin_n), .int_req(int_req), .int_nmi(int_nmi),
        .int_vector(int_vector), .int_ack(int_ack), .nmi_return(nmi_return),
        .global_enable_flag(global_enable_flag)
    );

    vip_core_model core (
        .ref_clk(ref_clk), .srst(srst), .int_req(int_req), .int_nmi(int_nmi),
        .ack_dly(ack_dly), .ret_dly(ret_dly), .int_ack(int_ack), .nmi_return(nmi_return)
    );

    // ==========================================================
    // helpers
    function automatic logic [15:0] vec_of(input int n);
        vec_of = (n == 0) ? 16'h0004 : 16'h0004 + 16'(2 * n);
    endfunction : vec_of

    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task results();
        $display("errors=%0d compares=%0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge ref_clk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            err_count++;
            results();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
            input logic err = 1'b0);
        rd_q.push_back('{m, e, err});
        apb(1'b0, a, 32'h0);
    endtask : rd

    task pulse(input logic [10:0] m);
        @(posedge ref_clk);
        src_pulse <= m;
        @(posedge ref_clk);
        src_pulse <= 11'h000;
    endtask : pulse

    task wait_acc(input int target);
        int n;
        for (n = 0; n < 300 && acc_cnt < target; n++) @(posedge ref_clk);
        if (acc_cnt < target) begin
            err_count++;
            results();
        end
        // one more edge so the acceptance side effects are settled when sampled
        @(posedge ref_clk);
    endtask : wait_acc

    // ==========================================================
    // result watchers: oldest note against each read and acceptance
    always @(posedge ref_clk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
            r_now = (rd_q.size() > 0) ? rd_q.pop_front() : '0;
            chk(prdata & r_now.m, r_now.e);
            chk({31'h0, pslverr}, {31'h0, r_now.err});
        end
        if (int_ack === 1'b1 && int_req === 1'b1) begin
            acc_cnt++;
            chk({15'h0, int_nmi, int_vector}, {15'h0, acc_q.pop_front()});
        end
    end

    // ==========================================================
    // main sequence
    initial begin
        srst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
        pwdata = 32'h0; src_pulse = 11'h000; ext_pin = 1'b0; key_pin_n = 8'hff;
        ack_dly = 4'h0; ret_dly = 8'h1e;
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        rd(OFS_REQ_FLAG, '1, 32'(RST_REQ_FLAG));
        rd(OFS_MASK_FLAG, '1, 32'(RST_MASK_FLAG));
        rd(OFS_EXT_EDGE, '1, 32'(RST_EXT_EDGE));
        rd(OFS_KEY_SEL, '1, 32'(RST_KEY_SEL));
        rd(OFS_CTRL, '1, 32'h0);
        rd(OFS_STATUS, '1, 32'h0);
        wr(8'h18, 32'hffffffff);
        rd(8'h18, '1, 32'h0, 1'b1);
        v = $random(seed);
        wr(OFS_MASK_FLAG, v);
        rd(OFS_MASK_FLAG, '1, v & 32'h7ff);
        v = $random(seed);
        wr(OFS_KEY_SEL, v);
        rd(OFS_KEY_SEL, '1, v & {24'h0, KEY_SEL_WMASK});
        // simultaneous requests held off by global enable, then served in order
        wr(OFS_CTRL, 32'h2);
        wr(OFS_MASK_FLAG, 32'h0);
        pend = 11'h3bf;
        pulse(pend);
        repeat (3) @(posedge ref_clk);
        chk({31'h0, int_req}, 32'h0);
        rd(OFS_REQ_FLAG, '1, {21'h0, pend});
        for (int i = 0; i < 11; i++) begin
            if (pend[i]) begin
                ack_dly <= 4'($unsigned($random(seed)) % 4);
                acc_q.push_back({1'b0, vec_of(i)});
                k = acc_cnt;
                wr(OFS_CTRL, 32'h3);
                wait_acc(k + 1);
                rd(OFS_CTRL, '1, 32'h2);
                pend[i] = 1'b0;
                rd(OFS_REQ_FLAG, '1, {21'h0, pend});
            end
        end
        // masked request waits for its mask to clear
        wr(OFS_MASK_FLAG, 32'h7ff);
        wr(OFS_CTRL, 32'h1);
        pulse(11'h100);
        repeat (4) @(posedge ref_clk);
        chk({31'h0, int_req}, 32'h0);
        rd(OFS_REQ_FLAG, '1, 32'h100);
        acc_q.push_back({1'b0, 16'h0014});
        k = acc_cnt;
        wr(OFS_MASK_FLAG, 32'h6ff);
        wait_acc(k + 1);
        chk({31'h0, global_enable_flag}, 32'h0);
        // watchdog in loop mode: nmi despite enable and masks off
        wr(OFS_CTRL, 32'h0);
        acc_q.push_back({1'b1, NMI_VECTOR});
        acc_q.push_back({1'b1, NMI_VECTOR});
        k = acc_cnt;
        pulse(11'h001);
        wait_acc(k + 1);
        rd(OFS_REQ_FLAG, '1, 32'h0);
        rd(OFS_STATUS, 32'h1, 32'h1);
        pulse(11'h001);
        repeat (3) @(posedge ref_clk);
        chk({31'h0, int_req}, 32'h0);
        wait_acc(k + 2);
        repeat (34) @(posedge ref_clk);
        rd(OFS_STATUS, 32'h1, 32'h0);
        // pin edge selection, every encoding
        for (int m = 0; m < 4; m++) begin
            wr(OFS_EXT_EDGE, 32'(m));
            wr(OFS_REQ_FLAG, 32'h0);
            @(posedge ref_clk) ext_pin <= 1'b1;
            repeat (3) @(posedge ref_clk);
            rd(OFS_REQ_FLAG, '1, (m == EDGE_RISE || m == EDGE_BOTH) ? 32'h40 : 32'h0);
            wr(OFS_REQ_FLAG, 32'h0);
            @(posedge ref_clk) ext_pin <= 1'b0;
            repeat (3) @(posedge ref_clk);
            rd(OFS_REQ_FLAG, '1, (m == EDGE_FALL || m == EDGE_BOTH) ? 32'h40 : 32'h0);
        end
        wr(OFS_EXT_EDGE, 32'(EDGE_FALL));
        wr(OFS_REQ_FLAG, 32'h0);
        wr(OFS_MASK_FLAG, 32'h7bf);
        wr(OFS_CTRL, 32'h1);
        acc_q.push_back({1'b0, 16'h0010});
        k = acc_cnt;
        @(posedge ref_clk) ext_pin <= 1'b1;
        repeat (2) @(posedge ref_clk);
        @(posedge ref_clk) ext_pin <= 1'b0;
        wait_acc(k + 1);
        // key return: mask first, then select, then clear the flag
        wr(OFS_MASK_FLAG, 32'h7ff);
        wr(OFS_KEY_SEL, 32'h10);
        wr(OFS_REQ_FLAG, 32'h0);
        @(posedge ref_clk) key_pin_n <= 8'hdf;
        repeat (3) @(posedge ref_clk);
        rd(OFS_REQ_FLAG, '1, 32'h0);
        @(posedge ref_clk) key_pin_n <= 8'hcf;
        repeat (3) @(posedge ref_clk);
        rd(OFS_REQ_FLAG, '1, 32'h400);
        wr(OFS_REQ_FLAG, 32'h0);
        @(posedge ref_clk) key_pin_n <= 8'hff;
        repeat (3) @(posedge ref_clk);
        rd(OFS_REQ_FLAG, '1, 32'h0);
        wr(OFS_KEY_SEL, 32'h01);
        wr(OFS_REQ_FLAG, 32'h0);
        @(posedge ref_clk) key_pin_n <= 8'hfb;
        repeat (3) @(posedge ref_clk);
        rd(OFS_REQ_FLAG, '1, 32'h400);
        acc_q.push_back({1'b0, 16'h0018});
        k = acc_cnt;
        wr(OFS_MASK_FLAG, 32'h3ff);
        wr(OFS_CTRL, 32'h1);
        wait_acc(k + 1);
        repeat (5) @(posedge ref_clk);
        results();
    end
endmodule : tb
